// [sma_defines.svh]
// Constants for the sum-of-products macrocell array: map, field positions, resets, timing.
// Assumes a 100 MHz system clock; included by bare name from the package and the array.
`ifndef SMA_DEFINES_SVH
`define SMA_DEFINES_SVH

// ---------------------------------------------------------------------------
// Array geometry
// ---------------------------------------------------------------------------
`define SMA_NUM_IN 12
`define SMA_NUM_MC 10
`define SMA_NUM_SIG 22
`define SMA_COLS 44
`define SMA_ROWS 132
`define SMA_MAX_TERMS 16
`define SMA_ROW_AR 0
`define SMA_ROW_SP 131

// ---------------------------------------------------------------------------
// Register port map (address 8 bits, data 44 bits)
// ---------------------------------------------------------------------------
`define SMA_AW 8
`define SMA_DW 44
`define SMA_ADDR_SEL 8'h84
`define SMA_ADDR_CTRL 8'h85
`define SMA_ADDR_ERASE 8'h86
`define SMA_ADDR_STAT 8'h87
`define SMA_CTRL_SECURE 0
`define SMA_CTRL_ZPWR 1
`define SMA_STAT_STBY_LSB 10
`define SMA_STAT_POR 20

// ---------------------------------------------------------------------------
// Erased values: link erased reads 1 (connected), select erased reads 1
// ---------------------------------------------------------------------------
`define SMA_LINK_ERASED 44'hFFFFFFFFFFF
`define SMA_SEL_ERASED 20'hFFFFF

// ---------------------------------------------------------------------------
// Timing
// ---------------------------------------------------------------------------
`define SMA_CLK_NS 10
`define SMA_STBY_NS 30
`define SMA_STBY_CYC (((`SMA_STBY_NS) + (`SMA_CLK_NS) - 1) / (`SMA_CLK_NS))
`define SMA_POR_NS 1000
`define SMA_POR_CYC ((`SMA_POR_NS) / (`SMA_CLK_NS))

`endif

// [sma_pkg.sv]
// Types shared by the sum-of-products macrocell array.
// Assumes sma_defines.svh is on the include path.
`include "sma_defines.svh"

package sma_pkg;
  // Per-macrocell configuration: polarity and register bypass.
  typedef struct packed {
    logic output_polarity_select;
    logic register_bypass_select;
  } sma_mc_cfg_s;

  // Register port request.
  typedef struct packed {
    logic wr_stb;
    logic rd_stb;
    logic [`SMA_AW-1:0] addr;
    logic [`SMA_DW-1:0] wdata;
  } sma_bus_s;

  typedef logic [`SMA_COLS-1:0] sma_row_t;
endpackage

// [sma_array.sv]
// Programmable sum-of-products array with ten output macrocells, loaded over a plain register port.
// Assumes one 100 MHz clock; all pins are asynchronous and are synchronised here.
// Summary of operation
// RQ1 - Term with no links is high; term linked to both polarities of an input is low.
// RQ2 - Twelve dedicated inputs and ten macrocells, each pin usable as bidirectional I/O.
// RQ3 - Each macrocell ORs a fixed term count between eight and sixteen.
// RQ4 - Select bit programmed reads 0 choosing path zero; erased reads 1.
// RQ5 - Every input enters the array in true and complemented form.
// RQ6 - Bypass select zero: flip-flop captures sum on clock rise; feedback is inverted Q.
// RQ7 - Bypass select one: output bypasses the flip-flop; feedback comes from the pin.
// RQ8 - Each output is three-state, enabled by its own product term.
// RQ9 - Combinatorial macrocell with enable always false works as a dedicated input.
// RQ10 - Polarity select one gives active high, for registered and combinatorial alike.
// RQ11 - Synchronous preset term high loads every register high on next clock rise.
// RQ12 - Asynchronous clear term high clears every register at once.
// RQ13 - Preset and clear act on flip-flops; pin level passes through polarity.
// RQ14 - After power-up all flip-flops are low within 1000 ns.
// RQ15 - Preload loads registers from output pins with arbitrary values.
// RQ16 - With security set, readback shows erased bits and preload is blocked.
// RQ17 - Security clears only with erasure of the whole pattern; here reset clears it as well.
// RQ18 - Zero-power: no input toggle for 30 ns enters standby; outputs hold.
// RQ19 - Clock pin toggles wake combinatorial macrocells only, not registered ones.
// RQ20 - Any input transition leaves standby.
// RQ21 - Zero-power: unused product terms are disabled.
// RQ22 - Configuration bits are loaded before operation and stay static.
//
// Chosen here: the plain strobed port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "sma_defines.svh"

module sma_array
  import sma_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic [`SMA_NUM_IN-2:0] dedicated_in,
  input wire logic shared_clock_input_pin,
  input wire logic preload_en,
  input wire logic [`SMA_NUM_MC-1:0] io_in,
  output logic [`SMA_NUM_MC-1:0] io_out,
  output logic [`SMA_NUM_MC-1:0] io_oe_n,
  input wire sma_bus_s bus,
  output logic [`SMA_DW-1:0] rdata
);

  // ---------------------------------------------------------------------------
  // Term distribution
  // ---------------------------------------------------------------------------
  function automatic int mc_terms(input int i);
    case (i)
      0, 9: mc_terms = 8;
      1, 8: mc_terms = 10;
      2, 7: mc_terms = 12;
      3, 6: mc_terms = 14;
      default: mc_terms = 16;
    endcase
  endfunction

  // First row of macrocell i: its enable term, followed by its sum terms.
  function automatic int mc_base(input int i);
    int acc;
    acc = 1;
    for (int j = 0; j < i; j++) begin
      acc = acc + 1 + mc_terms(j);
    end
    mc_base = acc;
  endfunction

  // ---------------------------------------------------------------------------
  // Reset release and pin synchronisers
  // ---------------------------------------------------------------------------
  logic rst_meta_reg;
  logic rst_n;
  localparam int PW = `SMA_NUM_IN + `SMA_NUM_MC + 1;
  logic [PW-1:0] pin_meta_reg;
  logic [PW-1:0] pin_sync_reg;
  logic [PW-1:0] pin_prev_reg;

  // Reset is asserted at once and released through two flip-flops.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rst_meta_reg <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n <= rst_meta_reg;
    end
  end

  // Every pin passes two flip-flops; a third copy gives the edge detectors a past value.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pin_meta_reg <= '0;
      pin_sync_reg <= '0;
      pin_prev_reg <= '0;
    end else begin
      pin_meta_reg <= {preload_en, io_in, dedicated_in, shared_clock_input_pin};
      pin_sync_reg <= pin_meta_reg;
      pin_prev_reg <= pin_sync_reg;
    end
  end

  logic clk_pin_s;
  logic [`SMA_NUM_IN-1:0] in_s;
  logic [`SMA_NUM_MC-1:0] io_s;
  logic preload_s;
  logic clk_rise;
  logic other_toggle;
  logic clk_toggle;
  assign clk_pin_s = pin_sync_reg[0];
  assign in_s = pin_sync_reg[`SMA_NUM_IN-1:0];
  assign io_s = pin_sync_reg[PW-2:`SMA_NUM_IN];
  assign preload_s = pin_sync_reg[PW-1];
  assign clk_rise = clk_pin_s & ~pin_prev_reg[0];
  assign clk_toggle = clk_pin_s ^ pin_prev_reg[0];
  assign other_toggle = |(pin_sync_reg[PW-2:1] ^ pin_prev_reg[PW-2:1]);

  // ---------------------------------------------------------------------------
  // Configuration store
  // ---------------------------------------------------------------------------
  sma_row_t links_reg [`SMA_ROWS];
  sma_mc_cfg_s [`SMA_NUM_MC-1:0] cfg_reg;
  logic secure_reg;
  logic zpwr_reg;
  logic wr_row;
  logic wr_erase;
  assign wr_row = bus.wr_stb && (bus.addr < 8'(`SMA_ROWS)) && !secure_reg;
  assign wr_erase = bus.wr_stb && (bus.addr == `SMA_ADDR_ERASE) && bus.wdata[0];

  // Links are flip-flops that hold the pattern until a reset or an erase; writes are refused while secured.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      for (int r = 0; r < `SMA_ROWS; r++) begin
        links_reg[r] <= `SMA_LINK_ERASED;
      end
    end else if (wr_erase) begin
      for (int r = 0; r < `SMA_ROWS; r++) begin
        links_reg[r] <= `SMA_LINK_ERASED;
      end
    end else if (wr_row) begin
      links_reg[bus.addr] <= bus.wdata; // [RQ22]
    end
  end

  // Select bits: erased reads 1, choosing path one of each multiplexer.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cfg_reg <= `SMA_SEL_ERASED; // [RQ4]
    end else if (wr_erase) begin
      cfg_reg <= `SMA_SEL_ERASED;
    end else if (bus.wr_stb && bus.addr == `SMA_ADDR_SEL && !secure_reg) begin
      cfg_reg <= bus.wdata[2*`SMA_NUM_MC-1:0];
    end
  end

  // Security can be set by a write but only a reset or an erase of the whole pattern clears it.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      secure_reg <= 1'b0;
      zpwr_reg <= 1'b0;
    end else begin
      if (wr_erase) begin
        secure_reg <= 1'b0; // [RQ17]
      end else if (bus.wr_stb && bus.addr == `SMA_ADDR_CTRL && bus.wdata[`SMA_CTRL_SECURE]) begin
        secure_reg <= 1'b1;
      end
      if (bus.wr_stb && bus.addr == `SMA_ADDR_CTRL) begin
        zpwr_reg <= bus.wdata[`SMA_CTRL_ZPWR];
      end
    end
  end

  // ---------------------------------------------------------------------------
  // AND array
  // ---------------------------------------------------------------------------
  logic [`SMA_NUM_MC-1:0] mc_q_reg;
  logic [`SMA_NUM_MC-1:0] fb;
  logic [`SMA_NUM_SIG-1:0] sig;
  logic [`SMA_COLS-1:0] cols;
  logic [`SMA_ROWS-1:0] pt;
  logic [`SMA_ROWS-1:0] pt_used;

  // Feedback: inverted Q when registered, the pin itself when combinatorial.
  always_comb begin
    for (int i = 0; i < `SMA_NUM_MC; i++) begin
      fb[i] = cfg_reg[i].register_bypass_select ? io_s[i] : ~mc_q_reg[i]; // [RQ6] [RQ7] [RQ9]
    end
  end
  assign sig = {fb, in_s}; // [RQ2]

  genvar gk;
  genvar gr;
  generate
    for (gk = 0; gk < `SMA_NUM_SIG; gk++) begin : g_col
      assign cols[2*gk] = sig[gk]; // [RQ5]
      assign cols[2*gk+1] = ~sig[gk];
    end
    // Open links pass 1, so an empty term is high and a true/complement pair forces it low.
    for (gr = 0; gr < `SMA_ROWS; gr++) begin : g_pt
      assign pt_used[gr] = ~zpwr_reg | ~(&links_reg[gr]); // [RQ21]
      assign pt[gr] = pt_used[gr] & (&(~links_reg[gr] | cols)); // [RQ1]
    end
  endgenerate

  // Unused terms in zero-power mode are all-linked rows; gating them changes no logic value.
  logic ar_term;
  logic sp_term;
  assign ar_term = pt[`SMA_ROW_AR];
  assign sp_term = pt[`SMA_ROW_SP];

  // ---------------------------------------------------------------------------
  // OR array
  // ---------------------------------------------------------------------------
  logic [`SMA_NUM_MC-1:0] sum;
  logic [`SMA_NUM_MC-1:0] oe_term;
  genvar gm;
  genvar gt;
  generate
    for (gm = 0; gm < `SMA_NUM_MC; gm++) begin : g_or
      localparam int BASE = mc_base(gm);
      localparam int NT = mc_terms(gm);
      assign oe_term[gm] = pt[BASE]; // [RQ8]
      assign sum[gm] = |pt[BASE+NT:BASE+1]; // [RQ3]
    end
  endgenerate

  // ---------------------------------------------------------------------------
  // Power-up hold
  // ---------------------------------------------------------------------------
  logic [6:0] por_cnt_reg;
  logic por_busy;
  assign por_busy = por_cnt_reg != 7'(`SMA_POR_CYC);

  // Registers are held low until the power-up delay runs out.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      por_cnt_reg <= 7'h00;
    end else if (por_busy) begin
      por_cnt_reg <= por_cnt_reg + 7'h01; // [RQ14]
    end
  end

  // ---------------------------------------------------------------------------
  // Macrocell flip-flops
  // ---------------------------------------------------------------------------
  logic preload_ok;
  assign preload_ok = preload_s && !secure_reg;

  // Clear is level sensitive and beats everything; the rest wait for a clock pin rise.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      mc_q_reg <= '0;
    end else if (por_busy) begin
      mc_q_reg <= '0; // [RQ14]
    end else if (ar_term) begin
      mc_q_reg <= '0; // [RQ12] [RQ13]
    end else if (clk_rise) begin
      if (preload_ok) begin
        mc_q_reg <= io_s; // [RQ15] [RQ16]
      end else if (sp_term) begin
        mc_q_reg <= '1; // [RQ11]
      end else begin
        mc_q_reg <= sum; // [RQ6]
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Standby detection
  // ---------------------------------------------------------------------------
  logic [1:0] idle_other_reg;
  logic [1:0] idle_all_reg;
  logic [`SMA_NUM_MC-1:0] standby;

  // Two idle counters: one ignores the clock pin for registered cells, one counts it.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      idle_other_reg <= 2'h0;
      idle_all_reg <= 2'h0;
    end else begin
      if (other_toggle) begin
        idle_other_reg <= 2'h0; // [RQ20]
      end else if (idle_other_reg != 2'(`SMA_STBY_CYC)) begin
        idle_other_reg <= idle_other_reg + 2'h1;
      end
      if (other_toggle || clk_toggle) begin
        idle_all_reg <= 2'h0; // [RQ19]
      end else if (idle_all_reg != 2'(`SMA_STBY_CYC)) begin
        idle_all_reg <= idle_all_reg + 2'h1;
      end
    end
  end

  always_comb begin
    for (int i = 0; i < `SMA_NUM_MC; i++) begin
      standby[i] = zpwr_reg && (cfg_reg[i].register_bypass_select ?
        (idle_all_reg == 2'(`SMA_STBY_CYC)) : (idle_other_reg == 2'(`SMA_STBY_CYC))); // [RQ18] [RQ19]
    end
  end

  // ---------------------------------------------------------------------------
  // Output pins
  // ---------------------------------------------------------------------------
  // Pin drivers are registered; a cell in standby keeps its last level and enable.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      io_out <= '0;
      io_oe_n <= '1;
    end else begin
      for (int i = 0; i < `SMA_NUM_MC; i++) begin
        if (por_busy) begin
          io_out[i] <= ~cfg_reg[i].output_polarity_select;
          io_oe_n[i] <= 1'b1;
        end else if (!standby[i]) begin
          io_out[i] <= ~(cfg_reg[i].output_polarity_select ^
            (cfg_reg[i].register_bypass_select ? sum[i] : mc_q_reg[i])); // [RQ10] [RQ13]
          io_oe_n[i] <= ~oe_term[i]; // [RQ8] [RQ9]
        end
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Register read port
  // ---------------------------------------------------------------------------
  // Secured readback returns erased values so the pattern cannot be copied.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= '0;
    end else if (bus.rd_stb) begin
      if (bus.addr < 8'(`SMA_ROWS)) begin
        rdata <= secure_reg ? `SMA_LINK_ERASED : links_reg[bus.addr]; // [RQ16]
      end else if (bus.addr == `SMA_ADDR_SEL) begin
        rdata <= {24'h000000, secure_reg ? `SMA_SEL_ERASED : 20'(cfg_reg)}; // [RQ16]
      end else if (bus.addr == `SMA_ADDR_CTRL) begin
        rdata <= {42'h0, zpwr_reg, secure_reg};
      end else if (bus.addr == `SMA_ADDR_STAT) begin
        rdata <= {23'h0, por_busy, standby, mc_q_reg};
      end else begin
        rdata <= '0;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  property p_async_clear;
    @(posedge clk_sys) disable iff (!rst_n) (ar_term && !wr_erase && !wr_row) |=> (mc_q_reg == '0);
  endproperty
  a_async_clear: assert property (p_async_clear) else $error("clear term did not clear registers"); // [RQ12]

  property p_sync_preset;
    @(posedge clk_sys) disable iff (!rst_n)
      (!por_busy && !ar_term && clk_rise && sp_term && !preload_ok) |=> (mc_q_reg == '1);
  endproperty
  a_sync_preset: assert property (p_sync_preset) else $error("preset term did not set registers"); // [RQ11]

  property p_hold_no_edge;
    @(posedge clk_sys) disable iff (!rst_n) (!por_busy && !ar_term && !clk_rise) |=> $stable(mc_q_reg);
  endproperty
  a_hold_no_edge: assert property (p_hold_no_edge) else $error("register changed without clock rise"); // [RQ6]

  property p_capture;
    @(posedge clk_sys) disable iff (!rst_n)
      (!por_busy && !ar_term && clk_rise && !sp_term && !preload_ok) |=> (mc_q_reg == $past(sum));
  endproperty
  a_capture: assert property (p_capture) else $error("register did not capture sum"); // [RQ6]

  property p_por;
    @(posedge clk_sys) disable iff (!rst_n) $rose(rst_n) ##0 por_busy |-> (mc_q_reg == '0) [*8];
  endproperty
  a_por: assert property (p_por) else $error("register not low during power-up"); // [RQ14]

  property p_por_oe;
    @(posedge clk_sys) disable iff (!rst_n) por_busy |=> (io_oe_n == '1);
  endproperty
  a_por_oe: assert property (p_por_oe) else $error("output enabled during power-up"); // [RQ14]

  property p_secure_read;
    @(posedge clk_sys) disable iff (!rst_n)
      (bus.rd_stb && secure_reg && bus.addr < 8'(`SMA_ROWS)) |=> (rdata == `SMA_LINK_ERASED);
  endproperty
  a_secure_read: assert property (p_secure_read) else $error("secured readback not erased"); // [RQ16]

  property p_secure_sticky;
    @(posedge clk_sys) disable iff (!rst_n) (secure_reg && !wr_erase) |=> secure_reg;
  endproperty
  a_secure_sticky: assert property (p_secure_sticky) else $error("security cleared without erase"); // [RQ17]

  property p_wake;
    @(posedge clk_sys) disable iff (!rst_n) other_toggle |=> (standby == '0);
  endproperty
  a_wake: assert property (p_wake) else $error("input toggle did not leave standby"); // [RQ20]

  property p_standby_entry;
    @(posedge clk_sys) disable iff (!rst_n)
      (zpwr_reg && !other_toggle && !clk_toggle) [*4] |-> (standby == '1);
  endproperty
  a_standby_entry: assert property (p_standby_entry) else $error("standby not entered when idle"); // [RQ18]

endmodule
`default_nettype wire

// [sma_board.sv]
// Board model for the macrocell array: resolves each macrocell pin from both drivers.
// Assumes the bench supplies the board-side level of every pin that the array leaves undriven.
`timescale 1ns/1ps
`default_nettype none

module sma_board
(
  input wire logic [9:0] io_out,
  input wire logic [9:0] io_oe_n,
  input wire logic [9:0] board_level,
  output logic [9:0] io_in
);
  // ---------------------------------------------------------------------------
  // Pin resolution
  // ---------------------------------------------------------------------------
  // A pin that the array drives shows its own level, so feedback and preload see the real wire.
  // An undriven pin shows the board level, which lets it serve as a dedicated input.
  always_comb begin
    for (int i = 0; i < 10; i++) begin
      io_in[i] = io_oe_n[i] ? board_level[i] : io_out[i];
    end
  end
endmodule

`default_nettype wire

// [sma_array_tb.sv]
// Self-checking bench for the macrocell array: programs rows and selects, then drives pins.
// Assumes the array package, the defines header and the board model are compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "sma_defines.svh"

module sma_array_tb;
  import sma_pkg::*;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic [10:0] din = '0;
  logic ck_pin = 1'b0;
  logic preload_en = 1'b0;
  logic [9:0] board_level = '0;
  logic [9:0] io_in;
  logic [9:0] io_out;
  logic [9:0] io_oe_n;
  logic [43:0] rdata;
  logic [43:0] d;
  sma_bus_s bus_q = '0;
  int n_errors = 0;
  int num_checks = 0;
  int cyc = 0;

  always #5 clk_sys = ~clk_sys;

  sma_array DUT (.clk_sys(clk_sys), .rstn(rstn), .dedicated_in(din), .shared_clock_input_pin(ck_pin),
    .preload_en(preload_en), .io_in(io_in), .io_out(io_out), .io_oe_n(io_oe_n), .bus(bus_q), .rdata(rdata));
  sma_board board (.io_out(io_out), .io_oe_n(io_oe_n), .board_level(board_level), .io_in(io_in));

  // ---------------------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------------------
  // Outputs are sampled 1 ns after an edge so that the edge's own updates have landed.
  task automatic wt(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  task automatic bus_wr(input logic [7:0] a, input logic [43:0] v);
    @(posedge clk_sys);
    bus_q <= '{wr_stb: 1'b1, rd_stb: 1'b0, addr: a, wdata: v};
    @(posedge clk_sys);
    bus_q.wr_stb <= 1'b0;
  endtask

  // Read data appear in the cycle after the strobe and hold until the next read; they are taken there.
  task automatic bus_rd(input logic [7:0] a, output logic [43:0] v);
    @(posedge clk_sys);
    bus_q <= '{wr_stb: 1'b0, rd_stb: 1'b1, addr: a, wdata: 44'h0};
    @(posedge clk_sys);
    bus_q.rd_stb <= 1'b0;
    #1;
    v = rdata;
  endtask

  // The clock pin is held for several cycles so that the synchroniser sees each level.
  task automatic pulse();
    @(posedge clk_sys);
    ck_pin <= 1'b1;
    wt(6);
    @(posedge clk_sys);
    ck_pin <= 1'b0;
    wt(6);
  endtask

  task automatic check(input logic [43:0] seen, input logic [43:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic wrap_up();
    $display("Checks made: %0d, mismatches: %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // A hang is cut off well beyond the few hundred cycles that the tests need.
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      wrap_up();
    end
  end

  // ---------------------------------------------------------------------------
  // Test sequence
  // ---------------------------------------------------------------------------
  initial begin
    repeat (5) @(posedge clk_sys);
    rstn <= 1'b1;
    wt(10);
    check(44'(io_oe_n), 44'h3FF);
    bus_rd(`SMA_ADDR_STAT, d);
    check(44'(d[20]), 44'h1);
    bus_rd(8'h83, d);
    check(d, `SMA_LINK_ERASED);
    bus_rd(`SMA_ADDR_SEL, d);
    check(d, 44'hFFFFF);
    bus_rd(8'hA0, d);
    check(d, 44'h0);
    wt(100);
    bus_rd(`SMA_ADDR_STAT, d);
    check(44'(d[20:0]), 44'h0);
    $display("Test reset done");
    // Cell 0 combinatorial: enable row with no links, one sum term on input 1.
    bus_wr(8'h01, 44'h0);
    bus_wr(8'h02, 44'h004);
    for (int i = 0; i < 2; i++) begin
      @(posedge clk_sys);
      din[0] <= i[0];
      wt(8);
      check(44'(io_out[0]), 44'(i[0]));
      check(44'(io_oe_n[0]), 44'h0);
      check(44'(io_oe_n[9]), 44'h1);
    end
    bus_wr(`SMA_ADDR_SEL, 44'hFFFFD);
    wt(6);
    check(44'(io_out[0]), 44'h0);
    bus_wr(`SMA_ADDR_SEL, 44'hFFFFF);
    bus_wr(8'h02, 44'h008);
    wt(6);
    check(44'(io_out[0]), 44'h0);
    // Sum term on the feedback of cell 2, whose pin is never enabled.
    bus_wr(8'h02, 44'h1 << 28);
    for (int i = 0; i < 2; i++) begin
      @(posedge clk_sys);
      board_level[2] <= ~i[0];
      wt(8);
      check(44'(io_out[0]), {43'h0, ~i[0]});
    end
    $display("Test combinatorial done");
    // Cell 1 registered, active high, always enabled, sum on input 1.
    bus_wr(`SMA_ADDR_SEL, 44'hFFFFB);
    bus_wr(8'h0A, 44'h0);
    bus_wr(8'h0B, 44'h004);
    @(posedge clk_sys);
    din[0] <= 1'b1;
    pulse();
    check(44'(io_out[1]), 44'h1);
    check(44'(io_oe_n[1]), 44'h0);
    @(posedge clk_sys);
    din[0] <= 1'b0;
    wt(8);
    check(44'(io_out[1]), 44'h1);
    pulse();
    check(44'(io_out[1]), 44'h0);
    // Cell 0 now sums the feedback of registered cell 1, which must be the inverted register.
    bus_wr(8'h02, 44'h1 << 26);
    wt(6);
    check(44'(io_out[0]), 44'h1);
    $display("Test registered done");
    bus_wr(8'h83, 44'h0);
    pulse();
    bus_rd(`SMA_ADDR_STAT, d);
    check(44'(d[9:0]), 44'h3FF);
    bus_wr(`SMA_ADDR_SEL, 44'hFFFF3);
    wt(6);
    check(44'(io_out[1]), 44'h0);
    bus_wr(8'h83, `SMA_LINK_ERASED);
    bus_wr(8'h00, 44'h0);
    wt(6);
    bus_rd(`SMA_ADDR_STAT, d);
    check(44'(d[9:0]), 44'h0);
    check(44'(io_out[1]), 44'h1);
    bus_wr(8'h00, `SMA_LINK_ERASED);
    $display("Test preset and clear done");
    @(posedge clk_sys);
    board_level <= 10'h2A4;
    preload_en <= 1'b1;
    pulse();
    @(posedge clk_sys);
    preload_en <= 1'b0;
    bus_rd(`SMA_ADDR_STAT, d);
    check(44'(d[9:2]), 44'hA9);
    $display("Test preload done");
    bus_wr(`SMA_ADDR_CTRL, 44'h1);
    bus_rd(8'h0B, d);
    check(d, `SMA_LINK_ERASED);
    @(posedge clk_sys);
    board_level <= 10'h158;
    preload_en <= 1'b1;
    pulse();
    @(posedge clk_sys);
    preload_en <= 1'b0;
    bus_rd(`SMA_ADDR_STAT, d);
    // Blocked preload leaves a normal capture; cells 2 to 9 have erased sums, so they load low.
    check(44'(d[9:2]), 44'h0);
    bus_wr(`SMA_ADDR_ERASE, 44'h1);
    bus_rd(8'h0B, d);
    check(d, `SMA_LINK_ERASED);
    bus_wr(8'h0B, 44'h004);
    bus_rd(8'h0B, d);
    check(d, 44'h004);
    $display("Test security done");
    bus_wr(`SMA_ADDR_CTRL, 44'h2);
    wt(10);
    bus_rd(`SMA_ADDR_STAT, d);
    check(44'(d[19:10]), 44'h3FF);
    $display("Test standby done");
    wrap_up();
  end
endmodule

`default_nettype wire
